// file: pal_pkg.sv
// Package for the symmetric PWM and converter trigger loop.
// Assumes one 50 MHz clock and an APB master with 32-bit data.
package pal_pkg;

    // ************************************************
    // Timing
    // ************************************************
    localparam int CLK_FREQ_KHZ = 50000;
    localparam int PWM_FREQ_KHZ = 250;
    // Whole switching period in clock cycles
    localparam int PWM_CYCLES   = CLK_FREQ_KHZ / PWM_FREQ_KHZ;
    localparam int CNT_W        = 16;
    // Up-down count peak: half the period
    localparam logic [CNT_W-1:0] PERIOD_RST = CNT_W'(PWM_CYCLES / 2);

    // ************************************************
    // Widths and fixed-point scaling
    // ************************************************
    localparam int ADC_W     = 12;
    localparam int AW        = 8;
    localparam int Q31_SHIFT = 31;
    localparam logic [47:0] Q31_ROUND = 48'h0000_7fff_ffff;

    // ************************************************
    // Register offsets (byte addresses)
    // ************************************************
    localparam logic [AW-1:0] OFS_CTRL   = 8'h00;
    localparam logic [AW-1:0] OFS_PERIOD = 8'h04;
    localparam logic [AW-1:0] OFS_CMP    = 8'h08;
    localparam logic [AW-1:0] OFS_CMPACT = 8'h0c;
    localparam logic [AW-1:0] OFS_DUTY   = 8'h10;
    localparam logic [AW-1:0] OFS_RESULT = 8'h14;
    localparam logic [AW-1:0] OFS_REF    = 8'h18;
    localparam logic [AW-1:0] OFS_ERROR  = 8'h1c;
    localparam logic [AW-1:0] OFS_STATUS = 8'h20;
    localparam logic [AW-1:0] OFS_MASK   = 8'h24;
    localparam logic [AW-1:0] OFS_COUNT  = 8'h28;

    // ************************************************
    // Fields and reset values
    // ************************************************
    localparam int CTRL_EN_BIT  = 0;
    localparam int ST_CONV_BIT  = 0;
    localparam int ST_PRD_BIT   = 1;
    localparam int STAT_W       = 2;
    localparam logic [CNT_W-1:0]  CMP_RST  = 16'h0000;
    localparam logic [ADC_W-1:0]  REF_RST  = 12'h000;
    localparam logic [STAT_W-1:0] MASK_RST = 2'h0;

    // ************************************************
    // Carriers
    // ************************************************
    typedef struct packed {
        logic          psel;
        logic          penable;
        logic          pwrite;
        logic [AW-1:0] paddr;
        logic [31:0]   pwdata;
    } pal_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } pal_apb_rsp_type;

    typedef struct packed {
        logic             done;
        logic [ADC_W-1:0] data;
    } pal_adc_in_type;

endpackage

// file: pal_pwm_adc_loop.sv
// Symmetric PWM generator with converter trigger and sample capture.
// Assumes one clock (mclk), an APB master, and a converter whose done
// and data pins are asynchronous, data stable before done rises.
//
// Local design decisions: the address map and register access over APB.

`timescale 1ns/100ps

module pal_pwm_adc_loop
    import pal_pkg::*;
#(
    parameter logic [CNT_W-1:0] PERIOD_DEF = PERIOD_RST
) (
    input  wire logic                     mclk,
    input  wire logic                     rstn,
    input  wire pal_pkg::pal_apb_req_type apb_req,
    output      pal_pkg::pal_apb_rsp_type apb_rsp,
    input  wire pal_pkg::pal_adc_in_type  adc_in,
    output      logic                     adc_start,
    output      logic                     switch_drive_output,
    output      logic                     irq
);

    import pal_pkg::*;

    // ************************************************
    // State
    // ************************************************
    typedef struct packed {
        logic             en;
        logic [CNT_W-1:0] period;
        logic [CNT_W-1:0] cmp_shadow;
        logic [CNT_W-1:0] cmp_active;
        logic [ADC_W-1:0] ref_val;
        logic [ADC_W-1:0] result;
        logic [ADC_W:0]   error;
        logic [STAT_W-1:0] status;
        logic [STAT_W-1:0] mask;
        logic [CNT_W-1:0] count;
        logic             down;
        logic             pwm;
        logic             start;
        logic             irq;
        logic             done_s1;
        logic             done_s2;
        logic             done_s3;
        logic [ADC_W-1:0] data_s1;
        logic [ADC_W-1:0] data_s2;
        pal_apb_rsp_type  rsp;
    } pal_state_type;

    pal_state_type state_reg;
    pal_state_type state_next;

    // ************************************************
    // Helpers
    // ************************************************

    // Q31 duty to compare count; period+1 so full scale is always on for periods 1 to 16'hfffe (at 16'hffff it wraps to 0)
    function automatic logic [CNT_W-1:0] duty_to_cmp(
        input logic [30:0]      duty,
        input logic [CNT_W-1:0] prd
    );
        logic [47:0] prod;
        prod = 48'(duty) * (48'(prd) + 48'h1) + Q31_ROUND;
        return prod[Q31_SHIFT +: CNT_W];
    endfunction

    // Zero-extend a narrow field onto the read bus
    function automatic logic [31:0] ext32(
        input logic [CNT_W-1:0] val
    );
        return {16'h0000, val};
    endfunction

    // ************************************************
    // Next-state logic
    // ************************************************
    always_comb begin
        logic             access;
        logic             wr;
        logic             rd;
        logic             hit;
        logic             at_peak;
        logic             at_valley;
        logic             done_edge;
        logic [STAT_W-1:0] events;
        logic [31:0]      rdata;

        access    = 1'b0;
        wr        = 1'b0;
        rd        = 1'b0;
        hit       = 1'b1;
        at_peak   = 1'b0;
        at_valley = 1'b0;
        done_edge = 1'b0;
        events    = '0;
        rdata     = 32'h0000_0000;

        state_next       = state_reg;
        state_next.start = 1'b0;
        state_next.rsp   = '0;

        // Two-stage sync; stage two feeds logic, plus a third done stage for the edge detect
        state_next.done_s1 = adc_in.done;
        state_next.done_s2 = state_reg.done_s1;
        state_next.done_s3 = state_reg.done_s2;
        state_next.data_s1 = adc_in.data;
        state_next.data_s2 = state_reg.data_s1;

        // ---------------- Period timer ----------------
        if (!state_reg.en) begin
            // Parked at the valley, output off
            state_next.count = '0;
            state_next.down  = 1'b0;
            state_next.pwm   = 1'b0;
        end else begin
            at_valley = (state_reg.count == '0);
            at_peak   = !at_valley && (state_reg.count >= state_reg.period);

            if (at_valley) begin
                state_next.down  = 1'b0;
                state_next.count = state_reg.count + 1'b1;
            end else if (at_peak) begin
                state_next.down  = 1'b1;
                state_next.count = state_reg.count - 1'b1;
            end else if (state_reg.down) begin
                state_next.count = state_reg.count - 1'b1;
            end else begin
                state_next.count = state_reg.count + 1'b1;
            end

            if (at_peak) begin
                state_next.cmp_active = state_reg.cmp_shadow;
                events[ST_PRD_BIT]    = 1'b1;
            end

            if (at_valley) begin
                state_next.start = 1'b1;
            end

            state_next.pwm = (state_next.count < state_next.cmp_active);
        end

        // ---------------- Converter capture ----------------
        // Rising edge of the synced done pin
        done_edge = state_reg.done_s2 && !state_reg.done_s3;

        if (done_edge) begin
            state_next.result = state_reg.data_s2;
            state_next.error  = {1'b0, state_reg.data_s2} - {1'b0, state_reg.ref_val};
            events[ST_CONV_BIT] = 1'b1;
        end

        // ---------------- APB slave ----------------
        // One wait state: pready comes from a flop
        access = apb_req.psel && apb_req.penable && !state_reg.rsp.pready;
        wr     = access && apb_req.pwrite;
        rd     = access && !apb_req.pwrite;

        // Register writes and read data select
        case (apb_req.paddr)
            OFS_CTRL: begin
                if (wr) begin
                    state_next.en = apb_req.pwdata[CTRL_EN_BIT];
                end
                rdata = {31'h0000_0000, state_reg.en};
            end
            OFS_PERIOD: begin
                if (wr) begin
                    state_next.period = apb_req.pwdata[CNT_W-1:0];
                end
                rdata = ext32(state_reg.period);
            end
            OFS_CMP: begin
                if (wr) begin
                    state_next.cmp_shadow = apb_req.pwdata[CNT_W-1:0];
                end
                rdata = ext32(state_reg.cmp_shadow);
            end
            OFS_CMPACT: begin
                rdata = ext32(state_reg.cmp_active);
            end
            OFS_DUTY: begin
                if (wr) begin
                    state_next.cmp_shadow = duty_to_cmp(apb_req.pwdata[30:0],
                                                        state_reg.period);
                end
                rdata = ext32(state_reg.cmp_shadow);
            end
            OFS_RESULT: begin
                rdata = {20'h0_0000, state_reg.result};
            end
            OFS_REF: begin
                if (wr) begin
                    state_next.ref_val = apb_req.pwdata[ADC_W-1:0];
                end
                rdata = {20'h0_0000, state_reg.ref_val};
            end
            OFS_ERROR: begin
                // Sign-extended two's complement
                rdata = {{19{state_reg.error[ADC_W]}}, state_reg.error};
            end
            OFS_STATUS: begin
                rdata = {30'h0000_0000, state_reg.status};
            end
            OFS_MASK: begin
                if (wr) begin
                    state_next.mask = apb_req.pwdata[STAT_W-1:0];
                end
                rdata = {30'h0000_0000, state_reg.mask};
            end
            OFS_COUNT: begin
                rdata = ext32(state_reg.count);
            end
            default: begin
                hit = 1'b0;
            end
        endcase

        // Sticky status: write one clears, a new event wins
        state_next.status = state_reg.status;
        if (wr && (apb_req.paddr == OFS_STATUS)) begin
            state_next.status = state_reg.status & ~apb_req.pwdata[STAT_W-1:0];
        end
        state_next.status = state_next.status | events;

        // Answer in the second access cycle
        if (access) begin
            state_next.rsp.pready  = 1'b1;
            state_next.rsp.pslverr = !hit;
            state_next.rsp.prdata  = (rd && hit) ? rdata : 32'h0000_0000;
        end

        state_next.irq = |(state_next.status & state_next.mask);
    end

    // ************************************************
    // State register
    // ************************************************
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_reg.en         <= 1'b0;
            state_reg.period     <= PERIOD_DEF;
            state_reg.cmp_shadow <= CMP_RST;
            state_reg.cmp_active <= CMP_RST;
            state_reg.ref_val    <= REF_RST;
            state_reg.result     <= '0;
            state_reg.error      <= '0;
            state_reg.status     <= '0;
            state_reg.mask       <= MASK_RST;
            state_reg.count      <= '0;
            state_reg.down       <= 1'b0;
            state_reg.pwm        <= 1'b0;
            state_reg.start      <= 1'b0;
            state_reg.irq        <= 1'b0;
            state_reg.done_s1    <= 1'b0;
            state_reg.done_s2    <= 1'b0;
            state_reg.done_s3    <= 1'b0;
            state_reg.data_s1    <= '0;
            state_reg.data_s2    <= '0;
            state_reg.rsp        <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ************************************************
    // Outputs, all straight from flops
    // ************************************************
    assign apb_rsp             = state_reg.rsp;
    assign adc_start           = state_reg.start;
    assign switch_drive_output = state_reg.pwm;
    assign irq                 = state_reg.irq;

endmodule // pal_pwm_adc_loop

// file: pal_pwm_adc_loop_assertions.sv
// Checker on the loop's top ports.
// Assumes a bind from the bench and one clock domain.
`timescale 1ns/100ps
module pal_pwm_adc_loop_assertions
    import pal_pkg::*;
#(
    parameter logic [CNT_W-1:0] PERIOD_DEF = PERIOD_RST
) (
    input wire logic                     mclk,
    input wire logic                     rstn,
    input wire pal_pkg::pal_apb_req_type apb_req,
    input wire pal_pkg::pal_apb_rsp_type apb_rsp,
    input wire pal_pkg::pal_adc_in_type  adc_in,
    input wire logic                     adc_start,
    input wire logic                     switch_drive_output,
    input wire logic                     irq
);
    logic [CNT_W-1:0] gap_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // Cycles since the last start, saturating so a stop looks long
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            gap_reg <= '1;
        end else if (adc_start) begin
            gap_reg <= '0;
        end else if (gap_reg != '1) begin
            gap_reg <= gap_reg + 1'b1;
        end
    end

    chk_start_pulse:
        assert property (adc_start |=> !adc_start) else $error("start pulse too long");
    chk_start_spacing:
        assert property (adc_start |-> gap_reg >= 2 * PERIOD_DEF - 1) else $error("starts too close");
    chk_start_centre:
        assert property (adc_start && switch_drive_output |-> $past(switch_drive_output))
            else $error("start not inside on pulse");
    chk_start_sym:
        assert property (adc_start && gap_reg == 2 * PERIOD_DEF - 1
            |-> switch_drive_output == $past(switch_drive_output, 2)) else $error("pulse not centred");
    chk_pready_wait:
        assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
            else $error("ready late");
    chk_pready_pulse:
        assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("ready stuck");
    chk_pready_cause:
        assert property (apb_rsp.pready |-> $past(apb_req.psel && apb_req.penable))
            else $error("ready without access");
    chk_err_pair:
        assert property (apb_rsp.pslverr |-> apb_rsp.pready) else $error("error without ready");
    chk_rdata_idle:
        assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0) else $error("read data outside ready");
endmodule // pal_pwm_adc_loop_assertions

// file: pal_adc_model.sv
// Converter model: one conversion per start pulse.
// Assumes the start pulse is registered on mclk.
`timescale 1ns/100ps
module pal_adc_model
    import pal_pkg::*;
#(
    parameter logic [ADC_W-1:0] SAMPLE = 12'h123
) (
    input  wire logic                    mclk,
    input  wire logic                    slow,
    input  wire logic                    adc_start,
    output      pal_pkg::pal_adc_in_type adc_in
);
    // ************
    // Conversion
    // ************
    // data settles before done, then is released
    initial begin
        adc_in = '{done: 1'b0, data: ~SAMPLE};
        forever begin
            @(posedge mclk);
            if (adc_start) begin
                adc_in.data <= SAMPLE;
                repeat (slow ? 2 : 1) @(posedge mclk);
                adc_in.done <= 1'b1;
                repeat (3) @(posedge mclk);
                adc_in.done <= 1'b0;
                repeat (2) @(posedge mclk);
                // Released pins show the inverse, not a stale value
                adc_in.data <= ~SAMPLE;
            end
        end
    end
endmodule // pal_adc_model

// file: pal_pwm_adc_loop_tb.sv
// Bench: APB tasks and call sequences with expected values.
// Assumes the converter model and the checker are compiled first.
`timescale 1ns/100ps
module pal_pwm_adc_loop_tb;
    import pal_pkg::*;
    localparam logic [CNT_W-1:0] PER = 16'h0004;
    localparam logic [ADC_W-1:0] SMP = 12'h123;
    logic            mclk;
    logic            rstn;
    logic            slow;
    pal_apb_req_type apb_req;
    pal_apb_rsp_type apb_rsp;
    pal_adc_in_type  adc_in;
    logic            adc_start;
    logic            switch_drive_output;
    logic            irq;
    logic [31:0]     q;
    logic            e;
    logic [63:0]     c;
    int              miscompares;
    int              check_count;
    int              cycles = 0;
    int              n;
    int              k;
    logic [31:0]     duty [3] = '{32'h0, 32'h4000_0000, 32'h7fff_ffff};
    logic [7:0]      ra [8] = '{OFS_CTRL, OFS_PERIOD, OFS_CMP, OFS_CMPACT, OFS_REF, OFS_STATUS, OFS_MASK, OFS_COUNT};

    pal_pwm_adc_loop #(.PERIOD_DEF(PER)) u_pal_pwm_adc_loop (.mclk(mclk), .rstn(rstn), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .adc_in(adc_in), .adc_start(adc_start),
        .switch_drive_output(switch_drive_output), .irq(irq));
    pal_adc_model #(.SAMPLE(SMP)) u_pal_adc_model (.mclk(mclk), .slow(slow), .adc_start(adc_start),
        .adc_in(adc_in));

    // ************
    // Tasks
    // ************
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One idle cycle first, so no signal is driven twice in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge mclk);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge mclk);
            t++;
        end while (apb_rsp.pready !== 1'b1 && t < 20);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req <= '0;
    endtask

    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, q, exp);
    endtask

    task automatic wait_start();
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (adc_start !== 1'b1 && n < 100);
    endtask

    task automatic on_count();
        k = 0;
        repeat (2 * PER) begin
            @(posedge mclk);
            k += int'(switch_drive_output === 1'b1);
        end
    endtask

    task automatic conclude();
        $display("miscompares %0d check_count %0d", miscompares, check_count);
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Hang guard, well above the few hundred cycles needed
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            miscompares++;
            conclude();
        end
    end

    // ************
    // Sequence
    // ************
    initial begin
        rstn = 1'b0;
        slow = 1'b0;
        apb_req = '0;
        miscompares = 0;
        check_count = 0;
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++) rd("reset value", ra[i], (i == 1) ? 32'(PER) : 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped error", 32'(e), 32'h1);
        apb(1'b1, OFS_CMPACT, 32'h5);
        apb(1'b1, OFS_CMP, 32'h2);
        rd("held compare", OFS_CMPACT, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h1);
        wait_start();
        wait_start();
        check("period", 32'(n), 32'(2 * PER));
        rd("loaded compare", OFS_CMPACT, 32'h2);
        on_count();
        check("on cycles", 32'(k), 32'h3);
        foreach (duty[i]) begin
            c = (64'(duty[i]) * (PER + 1) + 64'h7fff_ffff) >> 31;
            apb(1'b1, OFS_DUTY, duty[i]); // new duty lands on the valley in pass one, on the peak load edge later, so it applies from the following peak
            rd("duty map", OFS_DUTY, c[31:0]);
            wait_start();
            wait_start();
            on_count();
            check("duty on", 32'(k), 32'((c == 0) ? 0 : (2 * c - 1 > 2 * PER) ? 2 * PER : 2 * c - 1));
        end
        // Slow converter, masked first, then raised
        slow <= 1'b1;
        apb(1'b1, OFS_REF, 32'h800);
        apb(1'b1, OFS_STATUS, 32'h3);
        wait_start();
        wait_start();
        check("irq masked", 32'(irq), 32'h0);
        apb(1'b1, OFS_MASK, 32'h1);
        n = 0;
        while (irq !== 1'b1 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        check("irq raised", 32'(irq), 32'h1);
        rd("result", OFS_RESULT, 32'(SMP));
        rd("status both", OFS_STATUS, 32'h3);
        rd("error", OFS_ERROR, 32'(int'(SMP) - 2048));
        // Stop, let the last conversion land, then clear
        apb(1'b1, OFS_CTRL, 32'h0);
        repeat (12) @(posedge mclk);
        apb(1'b1, OFS_STATUS, 32'h3);
        rd("status clear", OFS_STATUS, 32'h0);
        check("irq clear", 32'(irq), 32'h0);
        conclude();
    end
endmodule // pal_pwm_adc_loop_tb

bind pal_pwm_adc_loop pal_pwm_adc_loop_assertions #(.PERIOD_DEF(PERIOD_DEF)) u_chk (.mclk(mclk), .rstn(rstn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .adc_in(adc_in), .adc_start(adc_start),
    .switch_drive_output(switch_drive_output), .irq(irq));
